// [hdl/swmc_microport.sv]
// Purpose: host microport and per-channel control of a 256 channel switch
// Assumes: bit_tick marks each serial bit, frame_pulse the first bit tick of a frame
// Notes:   memory ports alternate between serial jobs and the host
//
// Summary of operation
// - 8-bit data, six address, four control lines
// - all readable and writable, data memory read-only
// - host memory access interleaved with serial accesses
// - connect memory acknowledge within 800 ns
// - data memory acknowledge within 1220 ns
// - a5,a1,a0 low select control register
// - a5 high selects channel within page
// - split: reads data memory, writes low memory
// - memory_select picks memory when not split
// - stream_address picks the 32-location page
// - global message mode forces message and enable
// - high bit 2 message, else low gives source
// - output_drive_enable low floats all eight ser_out streams
// - high bit 0 enables channel output
// - 256 high bit-1 values shifted out per frame
// - control stream bit leads its channel one slot
// - high bit 3 picks variable or constant delay
// - low bits 7-5 stream, 4-0 channel
// - constant delay reads frame N data in N+2
// - output data fetched in preceding channel slot
`include "swmc_cfg.svh"
`default_nettype none
module swmc_microport (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       chip_select_n,
    input  wire logic       data_strobe,
    input  wire logic       read_not_write,
    input  wire logic [5:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       transfer_ack_n_in,
    output logic            transfer_ack_n_out,
    output logic            transfer_ack_n_oe,
    input  wire logic       frame_pulse,
    input  wire logic       bit_tick,
    input  wire logic [7:0] ser_in,
    output logic      [7:0] ser_out,
    output logic      [7:0] ser_oe,
    output logic            control_stream_out,
    input  wire logic       output_drive_enable
);
    initial begin
        if (`SWMC_CM_ACK_CYC < `SWMC_HOST_WORST) $error("swmc: ack limit too short");
        if (`SWMC_DM_ACK_CYC < `SWMC_HOST_WORST) $error("swmc: ack limit too short");
    end

    function automatic logic [1:0] inc3(input logic [1:0] b);
        return (b == 2'h2) ? 2'h0 : b + 2'h1;
    endfunction
    function automatic logic [1:0] dec3(input logic [1:0] b);
        return (b == 2'h0) ? 2'h2 : b - 2'h1;
    endfunction

    // ==================================================
    // frame timing and input capture
    logic [4:0] chan_reg,  chan_next;
    logic [2:0] bit_reg,   bit_next;
    logic [1:0] fbuf_reg,  fbuf_next;
    logic       slot_reg,  slot_next;
    logic [3:0] job_reg,   job_next;
    logic [7:0] in_sh_reg   [0:7];
    logic [7:0] in_sh_next  [0:7];
    logic [7:0] in_byte_reg [0:7];
    logic [7:0] in_byte_next[0:7];
    logic [4:0] in_chan_reg, in_chan_next;
    logic [1:0] in_buf_reg,  in_buf_next;
    logic       ch_start;

    assign ch_start = bit_tick && (frame_pulse || bit_reg == 3'h0);

    always_comb begin
        chan_next    = chan_reg;
        bit_next     = bit_reg;
        fbuf_next    = fbuf_reg;
        slot_next    = ~slot_reg;
        job_next     = job_reg;
        in_chan_next = in_chan_reg;
        in_buf_next  = in_buf_reg;
        in_sh_next   = in_sh_reg;
        in_byte_next = in_byte_reg;
        if (bit_tick) begin
            for (int s = 0; s < 8; s++) begin
                in_sh_next[s] = {in_sh_reg[s][6:0], ser_in[s]};
            end
            bit_next = bit_reg - 3'h1;
        end
        if (ch_start) begin
            bit_next     = 3'h7;
            chan_next    = frame_pulse ? 5'h00 : chan_reg + 5'h01;
            in_chan_next = chan_reg;
            in_buf_next  = fbuf_reg;
            in_byte_next = in_sh_next;
            job_next     = 4'h0;
            if (frame_pulse || chan_reg == 5'h1F) begin
                fbuf_next = inc3(fbuf_reg);
            end
        end else if (!slot_reg && job_reg != `SWMC_JOB_DONE) begin
            job_next = job_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_reg    <= 5'h00;
            bit_reg     <= 3'h7;
            fbuf_reg    <= 2'h0;
            slot_reg    <= 1'b0;
            job_reg     <= `SWMC_JOB_DONE;
            in_chan_reg <= 5'h00;
            in_buf_reg  <= 2'h0;
            for (int s = 0; s < 8; s++) begin
                in_sh_reg[s]   <= 8'h00;
                in_byte_reg[s] <= 8'h00;
            end
        end else begin
            chan_reg    <= chan_next;
            bit_reg     <= bit_next;
            fbuf_reg    <= fbuf_next;
            slot_reg    <= slot_next;
            job_reg     <= job_next;
            in_chan_reg <= in_chan_next;
            in_buf_reg  <= in_buf_next;
            in_sh_reg   <= in_sh_next;
            in_byte_reg <= in_byte_next;
        end
    end

    // ==================================================
    // memories
    logic       cm_we;
    logic [7:0] cm_waddr, cm_raddr, cml_q, cmh_q;
    logic       cml_we, cmh_we;
    logic       dm_we;
    logic [9:0] dm_waddr, dm_raddr;
    logic [7:0] dm_q;

    swmc_mem #(.WIDTH(8), .AW(8)) u_cml (
        .ref_clk (ref_clk), .we (cml_we), .waddr (cm_waddr),
        .wdata   (data_in), .raddr (cm_raddr), .rdata (cml_q)
    );
    swmc_mem #(.WIDTH(8), .AW(8)) u_cmh (
        .ref_clk (ref_clk), .we (cmh_we), .waddr (cm_waddr),
        .wdata   (data_in), .raddr (cm_raddr), .rdata (cmh_q)
    );
    swmc_mem #(.WIDTH(8), .AW(10)) u_dm (
        .ref_clk (ref_clk), .we (dm_we), .waddr (dm_waddr),
        .wdata   (in_byte_reg[job_reg[2:0]]), .raddr (dm_raddr), .rdata (dm_q)
    );

    // ==================================================
    // host port
    swmc_pkg::swmc_host_t state_reg, state_next;
    swmc_pkg::swmc_tgt_t  tgt_reg,   tgt_next;
    logic [7:0] ctrl_reg,  ctrl_next;
    logic [7:0] dout_reg,  dout_next;
    logic       rw_reg,    rw_next;
    logic [4:0] hch_reg,   hch_next;
    logic       req;
    logic       split;
    swmc_pkg::swmc_msel_t msel;
    swmc_pkg::swmc_tgt_t  tgt_dec;

    assign req   = !chip_select_n && data_strobe;
    assign split = ctrl_reg[`SWMC_CR_SPLIT];
    assign msel  = swmc_pkg::swmc_msel_t'(ctrl_reg[`SWMC_CR_MS_HI:`SWMC_CR_MS_LO]);

    always_comb begin
        tgt_dec = swmc_pkg::TG_NONE;
        if (!addr[`SWMC_A_PAGE]) begin
            if (addr[1:0] == 2'h0) begin
                tgt_dec = swmc_pkg::TG_CTRL;
            end
        end else if (split) begin
            tgt_dec = read_not_write ? swmc_pkg::TG_DM : swmc_pkg::TG_CML;
        end else begin
            case (msel)
                swmc_pkg::MS_CML: tgt_dec = swmc_pkg::TG_CML;
                swmc_pkg::MS_CMH: tgt_dec = swmc_pkg::TG_CMH;
                swmc_pkg::MS_DM:  tgt_dec = swmc_pkg::TG_DM;
                default:          tgt_dec = swmc_pkg::TG_NONE;
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        tgt_next   = tgt_reg;
        ctrl_next  = ctrl_reg;
        dout_next  = dout_reg;
        rw_next    = rw_reg;
        hch_next   = hch_reg;
        case (state_reg)
            swmc_pkg::HS_IDLE: begin
                if (req) begin
                    tgt_next   = tgt_dec;
                    rw_next    = read_not_write;
                    hch_next   = addr[`SWMC_A_CH_HI:0];
                    state_next = swmc_pkg::HS_WAIT;
                    if (tgt_dec == swmc_pkg::TG_CTRL) begin
                        state_next = swmc_pkg::HS_ACK;
                        if (read_not_write) begin
                            dout_next = ctrl_reg & ~(8'h01 << `SWMC_CR_UNUSED);
                        end else begin
                            ctrl_next = data_in;
                        end
                    end else if (tgt_dec == swmc_pkg::TG_NONE) begin
                        dout_next  = 8'h00;
                        state_next = swmc_pkg::HS_ACK;
                    end else if (tgt_dec == swmc_pkg::TG_DM && !read_not_write) begin
                        state_next = swmc_pkg::HS_ACK;
                    end
                end
            end
            swmc_pkg::HS_WAIT: begin
                if (slot_reg) begin
                    state_next = rw_reg ? swmc_pkg::HS_READ : swmc_pkg::HS_ACK;
                end
            end
            swmc_pkg::HS_READ: begin
                case (tgt_reg)
                    swmc_pkg::TG_CML: dout_next = cml_q;
                    swmc_pkg::TG_CMH: dout_next = cmh_q;
                    default:          dout_next = dm_q;
                endcase
                state_next = swmc_pkg::HS_ACK;
            end
            swmc_pkg::HS_ACK: begin
                if (!req) begin
                    state_next = swmc_pkg::HS_IDLE;
                end
            end
            default: state_next = swmc_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= swmc_pkg::HS_IDLE;
            tgt_reg   <= swmc_pkg::TG_NONE;
            ctrl_reg  <= `SWMC_CTRL_RST;
            dout_reg  <= 8'h00;
            rw_reg    <= 1'b1;
            hch_reg   <= 5'h00;
        end else begin
            state_reg <= state_next;
            tgt_reg   <= tgt_next;
            ctrl_reg  <= ctrl_next;
            dout_reg  <= dout_next;
            rw_reg    <= rw_next;
            hch_reg   <= hch_next;
        end
    end

    assign data_out           = dout_reg;
    assign data_oe            = state_reg == swmc_pkg::HS_ACK && rw_reg && req;
    assign transfer_ack_n_out = 1'b0;
    assign transfer_ack_n_oe  = state_reg == swmc_pkg::HS_ACK;

    // ==================================================
    // memory port sharing: serial on slot 0, host on slot 1
    logic        host_go, ser_go;
    logic [2:0]  prev_s;
    logic [7:0]  src;
    logic [4:0]  out_ch;
    logic [1:0]  out_buf, rd_buf;
    logic [7:0]  host_cm_addr;

    assign host_go      = state_reg == swmc_pkg::HS_WAIT && slot_reg;
    assign ser_go       = !slot_reg && job_reg != `SWMC_JOB_DONE;
    assign host_cm_addr = {ctrl_reg[`SWMC_CR_STA_HI:`SWMC_CR_STA_LO], hch_reg};
    assign cm_we        = host_go && !rw_reg;
    assign cm_waddr     = host_cm_addr;
    assign cml_we       = cm_we && tgt_reg == swmc_pkg::TG_CML;
    assign cmh_we       = cm_we && tgt_reg == swmc_pkg::TG_CMH;
    assign cm_raddr     = slot_reg ? host_cm_addr : {job_reg[2:0], chan_reg + 5'h02};
    assign dm_we        = ser_go && !job_reg[3];
    assign dm_waddr     = {in_buf_reg, job_reg[2:0], in_chan_reg};

    // ==================================================
    // fetch pipeline: a holds channel c+2, b channel c+1, c the one on the wire
    logic [7:0] cmh_a_reg [0:7], cmh_a_next [0:7];
    logic [7:0] cml_a_reg [0:7], cml_a_next [0:7];
    logic [7:0] cmh_b_reg [0:7], cmh_b_next [0:7];
    logic [7:0] cml_b_reg [0:7], cml_b_next [0:7];
    logic [7:0] dat_b_reg [0:7], dat_b_next [0:7];
    logic [7:0] oe_c_reg,  oe_c_next;
    logic       cmv_reg,   cmv_next;
    logic       dmv_reg,   dmv_next;
    logic [2:0] cms_reg,   cms_next;
    logic [2:0] dms_reg,   dms_next;
    logic [7:0] cst_load;
    logic [7:0] ser_load  [0:7];

    assign prev_s  = job_reg[2:0] - 3'h1;
    assign src     = cml_b_reg[prev_s];
    assign out_ch  = chan_reg + 5'h01;
    assign out_buf = (chan_reg == 5'h1F) ? inc3(fbuf_reg) : fbuf_reg;

    always_comb begin
        if (cmh_b_reg[prev_s][`SWMC_CMH_VC]) begin
            rd_buf = inc3(out_buf);
        end else begin
            rd_buf = ({1'b0, out_ch} > {1'b0, src[`SWMC_CML_CH_HI:0]} + 6'h02) ? out_buf : dec3(out_buf);
        end
    end

    assign dm_raddr = slot_reg ? {fbuf_reg, host_cm_addr}
                               : {rd_buf, src[`SWMC_CML_ST_HI:`SWMC_CML_ST_LO], src[`SWMC_CML_CH_HI:0]};

    always_comb begin
        cmh_a_next = cmh_a_reg;
        cml_a_next = cml_a_reg;
        cmh_b_next = cmh_b_reg;
        cml_b_next = cml_b_reg;
        dat_b_next = dat_b_reg;
        oe_c_next  = oe_c_reg;
        cmv_next   = ser_go && job_reg < 4'h8;
        dmv_next   = ser_go && job_reg != 4'h0;
        cms_next   = job_reg[2:0];
        dms_next   = prev_s;
        if (cmv_reg) begin
            cmh_a_next[cms_reg] = cmh_q;
            cml_a_next[cms_reg] = cml_q;
        end
        if (dmv_reg) begin
            dat_b_next[dms_reg] = dm_q;
        end
        if (ch_start) begin
            cmh_b_next = cmh_a_next;
            cml_b_next = cml_a_next;
            for (int s = 0; s < 8; s++) begin
                oe_c_next[s] = cmh_b_reg[s][`SWMC_CMH_OE] | ctrl_reg[`SWMC_CR_GMSG];
            end
        end
    end

    always_comb begin
        for (int s = 0; s < 8; s++) begin
            cst_load[7-s] = cmh_a_next[s][`SWMC_CMH_CST];
            if (ctrl_reg[`SWMC_CR_GMSG] || cmh_b_reg[s][`SWMC_CMH_MSG]) begin
                ser_load[s] = cml_b_reg[s];
            end else begin
                ser_load[s] = dat_b_next[s];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < 8; s++) begin
                cmh_a_reg[s] <= 8'h00;
                cml_a_reg[s] <= 8'h00;
                cmh_b_reg[s] <= 8'h00;
                cml_b_reg[s] <= 8'h00;
                dat_b_reg[s] <= 8'h00;
            end
            oe_c_reg <= 8'h00;
            cmv_reg  <= 1'b0;
            dmv_reg  <= 1'b0;
            cms_reg  <= 3'h0;
            dms_reg  <= 3'h0;
        end else begin
            cmh_a_reg <= cmh_a_next;
            cml_a_reg <= cml_a_next;
            cmh_b_reg <= cmh_b_next;
            cml_b_reg <= cml_b_next;
            dat_b_reg <= dat_b_next;
            oe_c_reg  <= oe_c_next;
            cmv_reg   <= cmv_next;
            dmv_reg   <= dmv_next;
            cms_reg   <= cms_next;
            dms_reg   <= dms_next;
        end
    end

    // ==================================================
    // serial outputs
    for (genvar g = 0; g < 8; g++) begin : g_out
        swmc_p2s #(.WIDTH(8)) u_p2s (
            .ref_clk   (ref_clk),
            .rst_b     (rst_b),
            .load      (ch_start),
            .load_data (ser_load[g]),
            .shift     (bit_tick),
            .sdo       (ser_out[g])
        );
    end

    swmc_p2s #(.WIDTH(8)) u_cst (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .load      (ch_start),
        .load_data (cst_load),
        .shift     (bit_tick),
        .sdo       (control_stream_out)
    );

    // the pin overrides everything, so hold it low until memories are set up
    assign ser_oe = output_drive_enable ? oe_c_reg : 8'h00;
endmodule
`default_nettype wire

// [include/swmc_cfg.svh]
// Purpose: constants of the switch microport and its serial timing
// Assumes: ref_clk at 10 MHz
// Notes:   every offset, field position, reset value and time count
`ifndef SWMC_CFG_SVH
`define SWMC_CFG_SVH
// ==================================================
// control register
`define SWMC_CTRL_RST    8'h00
`define SWMC_CR_SPLIT    7
`define SWMC_CR_GMSG     6
`define SWMC_CR_UNUSED   5
`define SWMC_CR_MS_HI    4
`define SWMC_CR_MS_LO    3
`define SWMC_CR_STA_HI   2
`define SWMC_CR_STA_LO   0
// ==================================================
// address decode
`define SWMC_A_PAGE      5
`define SWMC_A_CH_HI     4
// ==================================================
// connect memory high bits
`define SWMC_CMH_OE      0
`define SWMC_CMH_CST     1
`define SWMC_CMH_MSG     2
`define SWMC_CMH_VC      3
// ==================================================
// connect memory low fields
`define SWMC_CML_ST_HI   7
`define SWMC_CML_ST_LO   5
`define SWMC_CML_CH_HI   4
// ==================================================
// timing
`define SWMC_CLK_NS      100
`define SWMC_CM_ACK_NS   800
`define SWMC_DM_ACK_NS   1220
`define SWMC_CM_ACK_CYC  (`SWMC_CM_ACK_NS / `SWMC_CLK_NS)
`define SWMC_DM_ACK_CYC  (`SWMC_DM_ACK_NS / `SWMC_CLK_NS)
`define SWMC_HOST_WORST  5
`define SWMC_JOB_DONE    4'h9
`endif

// [include/swmc_pkg.sv]
// Purpose: types of the switch microport
// Assumes: nothing
// Notes:   state codes are one-hot
`default_nettype none
package swmc_pkg;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_WAIT = 4'h2,
        HS_READ = 4'h4,
        HS_ACK  = 4'h8
    } swmc_host_t;
    typedef enum logic [1:0] {
        MS_RSVD = 2'h0,
        MS_CML  = 2'h1,
        MS_CMH  = 2'h2,
        MS_DM   = 2'h3
    } swmc_msel_t;
    typedef enum logic [2:0] {
        TG_NONE = 3'h0,
        TG_CTRL = 3'h1,
        TG_CML  = 3'h2,
        TG_CMH  = 3'h3,
        TG_DM   = 3'h4
    } swmc_tgt_t;
endpackage
`default_nettype wire

// [hdl/swmc_mem.sv]
// Purpose: one write port, one registered read port memory
// Assumes: contents undefined after power up
// Notes:   read of a location written in the same cycle gives old data
`default_nettype none
module swmc_mem #(
    parameter int WIDTH = 8,
    parameter int AW    = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    initial begin
        if (WIDTH < 1 || AW < 1) $error("swmc_mem: bad size");
    end
    logic [WIDTH-1:0] store [0:(1<<AW)-1];
    always_ff @(posedge ref_clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end
endmodule
`default_nettype wire

// [hdl/swmc_p2s.sv]
// Purpose: parallel to serial converter, msb first
// Assumes: load and shift come on the bit tick
// Notes:   load wins over shift so the first bit leaves at once
`default_nettype none
module swmc_p2s #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_data,
    input  wire logic             shift,
    output logic                  sdo
);
    initial begin
        if (WIDTH < 2) $error("swmc_p2s: width below 2");
    end
    logic [WIDTH-1:0] sh_reg;
    logic [WIDTH-1:0] sh_next;
    always_comb begin
        sh_next = sh_reg;
        if (load) begin
            sh_next = load_data;
        end else if (shift) begin
            sh_next = {sh_reg[WIDTH-2:0], 1'b0};
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end
    assign sdo = sh_reg[WIDTH-1];
endmodule
`default_nettype wire

// [testbench/swmc_microport_chk.sv]
// Purpose: port checker of the switch microport
// Assumes: one clock, rst_b async active low
// Notes:   bound to every swmc_microport instance
`default_nettype none
module swmc_chk (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       chip_select_n,
    input wire logic       data_strobe,
    input wire logic       read_not_write,
    input wire logic       data_oe,
    input wire logic       transfer_ack_n_out,
    input wire logic       transfer_ack_n_oe,
    input wire logic       bit_tick,
    input wire logic [7:0] ser_out,
    input wire logic [7:0] ser_oe,
    input wire logic       control_stream_out,
    input wire logic       output_drive_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic req;
    assign req = !chip_select_n && data_strobe;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // ====
    // host handshake
    AST_ACK_MAX: assert property (req && !transfer_ack_n_oe |-> ##[1:12] transfer_ack_n_oe)
        else $error("ack later than allowed");
    AST_ACK_HOLD: assert property (req && transfer_ack_n_oe |=> transfer_ack_n_oe)
        else $error("ack dropped under strobe");
    AST_ACK_REL: assert property (transfer_ack_n_oe && !req |=> !transfer_ack_n_oe)
        else $error("ack kept after strobe");
    AST_ACK_CAUSE: assert property ($rose(transfer_ack_n_oe) |-> $past(req))
        else $error("ack without request");
    AST_ACK_LOW: assert property (transfer_ack_n_out == 1'h0)
        else $error("ack pin not open drain");
    AST_DOE_READ: assert property (data_oe |-> transfer_ack_n_oe && read_not_write && req)
        else $error("data bus driven outside read ack");
    // ====
    // serial side
    AST_ODE_OFF: assert property (!output_drive_enable |-> ser_oe == 8'h00)
        else $error("serial output driven while disabled");
    AST_CSO_TICK: assert property ($changed(control_stream_out) |-> $past(bit_tick))
        else $error("control stream moved off tick");
    AST_SER_TICK: assert property ($changed(ser_out) |-> $past(bit_tick))
        else $error("serial data moved off tick");
endmodule
bind swmc_microport swmc_chk u_swmc_chk (.*);
`default_nettype wire

// [testbench/swmc_host.sv]
// Purpose: host processor model on the parallel port
// Assumes: one access at a time
// Notes:   released lines show inverted values so stale data never matches
`default_nettype none
module swmc_host (
    input  wire logic       ref_clk,
    output logic            chip_select_n,
    output logic            data_strobe,
    output logic            read_not_write,
    output logic      [5:0] addr,
    output logic      [7:0] data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       transfer_ack_n_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        chip_select_n = 1'h1;
        data_strobe = 1'h0;
        read_not_write = 1'h1;
        addr = 6'h00;
        data_in = 8'h00;
    end
    // ====
    // one bus cycle, lat is -1 when no ack came
    task automatic access(input logic rnw, input logic [5:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output int lat);
        lat = 0;
        @(posedge ref_clk);
        #1;
        chip_select_n = 1'h0;
        data_strobe = 1'h1;
        read_not_write = rnw;
        addr = a;
        data_in = wd;
        do begin
            @(posedge ref_clk);
            lat++;
        end while (!transfer_ack_n_oe && lat < 40);
        rd = data_out;
        if (!transfer_ack_n_oe) lat = -1;
        #1;
        chip_select_n = 1'h1;
        data_strobe = 1'h0;
        addr = ~a;
        data_in = ~wd;
        // ack falls at this edge, so the next request lands in idle
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [testbench/test_switch_microport_control.sv]
// Purpose: self-checking bench of the switch microport
// Assumes: bit ticks every 3 clocks, 256 per frame
// Notes:   constant serial input makes every data byte predictable
`default_nettype none
module test_switch_microport_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CSP = 8'hB2;
    logic       ref_clk, rst_b, chip_select_n, data_strobe, read_not_write, data_oe;
    logic       transfer_ack_n_in, transfer_ack_n_out, transfer_ack_n_oe;
    logic       frame_pulse, bit_tick, control_stream_out, output_drive_enable;
    logic [5:0] addr;
    logic [7:0] data_in, data_out, ser_in, ser_out, ser_oe, tcnt, rd;
    logic [1:0] div;
    int         n_fail, n_compared, lat;
    swmc_microport u_swmc_microport (.*);
    swmc_host u_swmc_host (.*);
    assign transfer_ack_n_in = transfer_ack_n_oe ? transfer_ack_n_out : 1'h1;
    // ====
    // clock and serial timing
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        {div, tcnt, bit_tick, frame_pulse} = {2'h0, 8'hFF, 2'h0};
        ser_in = 8'h5A;
    end
    always @(posedge ref_clk) begin
        #1;
        div = (div == 2'h2) ? 2'h0 : div + 2'h1;
        bit_tick = (div == 2'h0);
        if (bit_tick) tcnt = tcnt + 8'h01;
        frame_pulse = bit_tick && (tcnt == 8'h00);
    end
    // ====
    // shared tasks
    task automatic print_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_lat(input int lim);
        n_compared++;
        if (lat > lim) begin
            n_fail++;
            $display("ERROR ack_delay exp <=%0d got %0d", lim, lat);
        end
    endtask
    task automatic acc(input logic rnw, input logic [5:0] a, input logic [7:0] wd);
        u_swmc_host.access(rnw, a, wd, rd, lat);
        if (lat < 0) begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic wr2(input logic [7:0] c, input logic [5:0] a, input logic [7:0] d);
        acc(1'h0, 6'h00, c);
        acc(1'h0, a, d);
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [5:0] a, input logic [7:0] e, input string nm);
        acc(1'h0, 6'h00, c);
        acc(1'h1, a, 8'h00);
        chk8(nm, e, rd);
    endtask
    // bounded wait for a given tick of the frame, then let outputs settle
    task automatic wait_tick(input logic [7:0] n);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge ref_clk);
            if (bit_tick && tcnt == n) break;
        end
        if (i == 2000) begin
            n_fail++;
            print_verdict();
        end
        #1;
    endtask
    // ====
    // scenarios
    task automatic t_ctrl;
        acc(1'h0, 6'h1C, 8'h3B);
        acc(1'h1, 6'h00, 8'h00);
        chk8("ctrl", 8'h1B, rd);
        acc(1'h0, 6'h02, 8'hFF);
        acc(1'h1, 6'h1D, 8'h00);
        chk8("unmapped", 8'h00, rd);
        acc(1'h1, 6'h14, 8'h00);
        chk8("ctrl_kept", 8'h1B, rd);
        $display("t_ctrl done");
    endtask
    task automatic t_mem;
        wr2(8'h0D, 6'h27, 8'hC3);
        wr2(8'h15, 6'h27, 8'h0D);
        wr2(8'h0E, 6'h27, 8'h66);
        acc(1'h0, 6'h28, 8'h77);
        rdchk(8'h0D, 6'h27, 8'hC3, "cml");
        chk_lat(8);
        rdchk(8'h15, 6'h27, 8'h0D, "cmh");
        rdchk(8'h0E, 6'h27, 8'h66, "cml_s6");
        rdchk(8'h05, 6'h27, 8'h00, "rsvd");
        $display("t_mem done");
    endtask
    task automatic t_serial;
        logic [7:0] cs, so;
        for (int s = 0; s < 8; s++) wr2({5'h02, s[2:0]}, 6'h20, {6'h00, CSP[7-s], 1'h1});
        for (int i = 0; i < 32; i++) wr2(8'h0A, {1'h1, i[4:0]}, 8'hA5);
        acc(1'h0, 6'h00, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wait_tick(8'hF8 + 8'(i));
            cs[7 - i] = control_stream_out;
        end
        for (int i = 0; i < 8; i++) begin
            wait_tick(8'(i));
            so[7 - i] = ser_out[2];
        end
        chk8("cso", CSP, cs);
        chk8("msg_out", 8'hA5, so);
        chk8("msg_oe", 8'hFF, ser_oe);
        output_drive_enable = 1'h0;
        #1;
        chk8("ode_off", 8'h00, ser_oe);
        @(posedge ref_clk);
        #1;
        output_drive_enable = 1'h1;
        $display("t_serial done");
    endtask
    // three frames pass first so every data buffer holds the constant input
    task automatic t_split;
        repeat (3) wait_tick(8'h50);
        wr2(8'h86, 6'h27, 8'h99);
        acc(1'h1, 6'h27, 8'h00);
        chk8("split_rd", 8'hFF, rd);
        rdchk(8'h0E, 6'h27, 8'h99, "split_wr");
        wr2(8'h1E, 6'h27, 8'h11);
        acc(1'h1, 6'h27, 8'h00);
        chk_lat(12);
        chk8("dm_rd", 8'hFF, rd);
        rdchk(8'h0E, 6'h27, 8'h99, "dm_ro");
        wr2(8'h0A, 6'h20, 8'h25);
        wr2(8'h12, 6'h20, 8'h09);
        wait_tick(8'h50);
        for (int i = 0; i < 8; i++) begin
            wait_tick(8'(i));
            rd[7 - i] = ser_out[2];
        end
        chk8("conn_out", 8'hFF, rd);
        $display("t_split done");
    endtask
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_b = 1'h0;
        output_drive_enable = 1'h1;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'h1;
        t_ctrl();
        t_mem();
        t_serial();
        t_split();
        print_verdict();
    end
endmodule
`default_nettype wire
